// ### src/crm_map.svh
// Register offsets, field positions, reset values and timing counts of the rate meter block
`ifndef CRM_MAP_SVH
`define CRM_MAP_SVH
// Byte offsets on the register bus
`define CRM_OFF_REF_CONFIG   8'h00
`define CRM_OFF_ACTION       8'h04
`define CRM_OFF_OUT_POL      8'h08
`define CRM_OFF_PATH_CTRL    8'h0C
`define CRM_OFF_RATIO_HIGH   8'h10
`define CRM_OFF_RATIO_MID    8'h14
`define CRM_OFF_RATIO_LOW    8'h18
`define CRM_OFF_MISC         8'h1C
`define CRM_OFF_RATE_CODE    8'h20
`define CRM_OFF_SUBHARM      8'h24
`define CRM_OFF_UPPER_CODE   8'h28
`define CRM_OFF_LOWER_CODE   8'h2C
`define CRM_OFF_MODE_SEL     8'h30
// Field positions
`define CRM_ACT_RESTART_BIT  3
`define CRM_ACT_REACQ_BIT    5
`define CRM_POL_LOS_BIT      2
`define CRM_MISC_DONE_BIT    2
`define CRM_MODE_HOLD_A_BIT  2
`define CRM_MODE_HOLD_B_BIT  1
// Reset values
`define CRM_RST_BYTE         8'h00
`define CRM_RST_CODE         9'h000
// Measurement window base exponent and rate tick prescale
`define CRM_WIN_BASE_EXP     5'd14
`define CRM_TICK_SHIFT       5'd8
// Typical measurement time in ms, for reference by software timeouts
`define CRM_MEAS_TYP_MS      80
`endif

// ### src/crm_pkg.sv
// Types shared by the rate meter block
package crm_pkg;
    // Reference configuration byte
    typedef struct packed {
        logic [1:0] ref_range;
        logic [3:0] ref_ratio;
        logic fine_meas_en;
        logic lock_ref_en;
    } crm_ref_cfg_t;
    // Path control byte
    typedef struct packed {
        logic bypass;
        logic lvds_off;
        logic cml_off;
        logic [4:0] spare;
    } crm_path_t;
    // Subharmonic mode byte
    typedef struct packed {
        logic enable;
        logic [4:0] ratio;
        logic [1:0] code_lsb;
    } crm_sub_t;
    // Measurement sequencer states
    typedef enum logic [1:0] {
        CRM_IDLE,
        CRM_RUN,
        CRM_DONE
    } crm_meas_t;
endpackage : crm_pkg

// ### src/crm_top.sv
// Control registers, fine rate meter and output controls of the data recovery receiver
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "crm_map.svh"

// How it works
// - Two-bit range field selects reference band
// - Fine measurement enable acts as level
// - Restart bit one-then-zero starts measurement
// - Done flag low running, high finished
// - Ratio returned as three bytes, 23 bits
// - Ratio equals 256 times rate times 2^(14+range) over ref
// - Measurement never touches lock behaviour
// - Coarse word: rate code plus misc bit
// - Signal-loss polarity bit selects active level
// - Re-acquire bit pulse restarts acquisition
// - Subharmonic mode enable bit
// - Squelch outputs in subharmonic until lock
// - Holdover A: only software restarts acquisition
// - Holdover B: rate change restarts acquisition
// - Bypass bit routes input past recovery
// - Bits six and five disable output buffers
module crm_top
    import crm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and recovery loop side
    input wire logic reference_clock,
    input wire logic rate_tick,
    input wire logic lock_lost,
    input wire logic signal_lost,
    input wire logic rate_change,
    input wire logic [8:0] coarse_rate,
    output logic signal_lost_pin,
    output logic acquire_start,
    output logic squelch,
    output logic bypass_en,
    output logic lvds_off,
    output logic cml_off,
    output logic lock_ref_en,
    output logic [5:0] ref_lock_cfg,
    output logic sub_en,
    output logic [4:0] sub_ratio,
    output logic [19:0] sub_codes,
    output logic hold_a,
    output logic hold_b
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [3:0] sync1_q; // First stage, read only by second
    logic [3:0] sync2_q; // Safe copies
    logic ref_prev_q; // Reference level one cycle ago
    logic tick_prev_q; // Rate tick level one cycle ago
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            ref_prev_q <= 1'b0;
            tick_prev_q <= 1'b0;
        end else begin
            sync1_q <= {signal_lost, lock_lost, rate_tick, reference_clock};
            sync2_q <= sync1_q;
            ref_prev_q <= sync2_q[0];
            tick_prev_q <= sync2_q[1];
        end
    end
    logic ref_rise; // Reference rising edge
    logic tick_rise; // Rate tick rising edge
    assign ref_rise = sync2_q[0] & ~ref_prev_q;
    assign tick_rise = sync2_q[1] & ~tick_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register file and AXI4-Lite slave
    crm_ref_cfg_t ref_cfg_q, ref_cfg_d; // Reference configuration
    logic [7:0] action_q, action_d; // Action bits
    logic [7:0] pol_q, pol_d; // Output polarity
    crm_path_t path_q, path_d; // Path control
    crm_sub_t sub_q, sub_d; // Subharmonic mode
    logic [8:0] upper_q, upper_d; // Upper rate code
    logic [8:0] lower_q, lower_d; // Lower rate code
    logic [7:0] mode_q, mode_d; // Mode select
    logic aw_have_q, aw_have_d; // Write address held
    logic w_have_q, w_have_d; // Write data held
    logic [7:0] aw_addr_q, aw_addr_d; // Held write address
    logic [31:0] w_data_q, w_data_d; // Held write data
    logic [3:0] w_strb_q, w_strb_d; // Held byte enables
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [22:0] ratio_q; // Latched measured ratio
    logic done_q; // Measurement done flag

    always_comb begin
        logic [7:0] wb;
        logic hit;
        wb = 8'h00;
        hit = 1'b0;
        ref_cfg_d = ref_cfg_q;
        action_d = action_q;
        pol_d = pol_q;
        path_d = path_q;
        sub_d = sub_q;
        upper_d = upper_q;
        lower_d = lower_q;
        mode_d = mode_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        // Take address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        // Both halves present: perform write
        if (aw_have_q && w_have_q && !bvalid_q) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            hit = 1'b1;
            wb = w_strb_q[0] ? w_data_q[7:0] : 8'h00;
            if (aw_addr_q == `CRM_OFF_REF_CONFIG) begin
                if (w_strb_q[0]) ref_cfg_d = crm_ref_cfg_t'(wb);
            end else if (aw_addr_q == `CRM_OFF_ACTION) begin
                if (w_strb_q[0]) action_d = wb;
            end else if (aw_addr_q == `CRM_OFF_OUT_POL) begin
                if (w_strb_q[0]) pol_d = wb;
            end else if (aw_addr_q == `CRM_OFF_PATH_CTRL) begin
                if (w_strb_q[0]) path_d = crm_path_t'(wb);
            end else if (aw_addr_q == `CRM_OFF_SUBHARM) begin
                if (w_strb_q[0]) sub_d = crm_sub_t'(wb);
            end else if (aw_addr_q == `CRM_OFF_UPPER_CODE) begin
                if (w_strb_q[0]) upper_d[7:0] = wb;
                if (w_strb_q[1]) upper_d[8] = w_data_q[8];
            end else if (aw_addr_q == `CRM_OFF_LOWER_CODE) begin
                if (w_strb_q[0]) lower_d[7:0] = wb;
                if (w_strb_q[1]) lower_d[8] = w_data_q[8];
            end else if (aw_addr_q == `CRM_OFF_MODE_SEL) begin
                if (w_strb_q[0]) mode_d = wb;
            end else if (aw_addr_q == `CRM_OFF_RATIO_HIGH || aw_addr_q == `CRM_OFF_RATIO_MID
                    || aw_addr_q == `CRM_OFF_RATIO_LOW || aw_addr_q == `CRM_OFF_MISC
                    || aw_addr_q == `CRM_OFF_RATE_CODE) begin
                hit = 1'b1; // Read-only, write ignored
            end else begin
                hit = 1'b0;
            end
            bresp_d = hit ? 2'b00 : 2'b10;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // Read: answer one cycle after address taken
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = 2'b00;
            rdata_d = 32'h0000_0000;
            if (s_axi_araddr == `CRM_OFF_REF_CONFIG) begin
                rdata_d[7:0] = ref_cfg_q;
            end else if (s_axi_araddr == `CRM_OFF_ACTION) begin
                rdata_d[7:0] = action_q;
            end else if (s_axi_araddr == `CRM_OFF_OUT_POL) begin
                rdata_d[7:0] = pol_q;
            end else if (s_axi_araddr == `CRM_OFF_PATH_CTRL) begin
                rdata_d[7:0] = path_q;
            end else if (s_axi_araddr == `CRM_OFF_RATIO_HIGH) begin
                rdata_d[6:0] = ratio_q[22:16];
            end else if (s_axi_araddr == `CRM_OFF_RATIO_MID) begin
                rdata_d[7:0] = ratio_q[15:8];
            end else if (s_axi_araddr == `CRM_OFF_RATIO_LOW) begin
                rdata_d[7:0] = ratio_q[7:0];
            end else if (s_axi_araddr == `CRM_OFF_MISC) begin
                rdata_d[`CRM_MISC_DONE_BIT] = done_q;
                rdata_d[0] = coarse_rate[0];
            end else if (s_axi_araddr == `CRM_OFF_RATE_CODE) begin
                rdata_d[7:0] = coarse_rate[8:1];
            end else if (s_axi_araddr == `CRM_OFF_SUBHARM) begin
                rdata_d[7:0] = sub_q;
            end else if (s_axi_araddr == `CRM_OFF_UPPER_CODE) begin
                rdata_d[8:0] = upper_q;
            end else if (s_axi_araddr == `CRM_OFF_LOWER_CODE) begin
                rdata_d[8:0] = lower_q;
            end else if (s_axi_araddr == `CRM_OFF_MODE_SEL) begin
                rdata_d[7:0] = mode_q;
            end else begin
                rresp_d = 2'b10; // Unmapped
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // Ready terms: one transfer of each kind at a time
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Register state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ref_cfg_q <= crm_ref_cfg_t'(`CRM_RST_BYTE);
            action_q <= `CRM_RST_BYTE;
            pol_q <= `CRM_RST_BYTE;
            path_q <= crm_path_t'(`CRM_RST_BYTE);
            sub_q <= crm_sub_t'(`CRM_RST_BYTE);
            upper_q <= `CRM_RST_CODE;
            lower_q <= `CRM_RST_CODE;
            mode_q <= `CRM_RST_BYTE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'b00;
        end else begin
            ref_cfg_q <= ref_cfg_d;
            action_q <= action_d;
            pol_q <= pol_d;
            path_q <= path_d;
            sub_q <= sub_d;
            upper_q <= upper_d;
            lower_q <= lower_d;
            mode_q <= mode_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Action bit falling edges
    logic restart_prev_q; // Restart bit last cycle
    logic reacq_prev_q; // Re-acquire bit last cycle
    logic restart_go; // One then zero seen on restart
    logic reacq_go; // One then zero seen on re-acquire
    assign restart_go = restart_prev_q & ~action_q[`CRM_ACT_RESTART_BIT];
    assign reacq_go = reacq_prev_q & ~action_q[`CRM_ACT_REACQ_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Fine rate measurement: count rate ticks over 2^(14+range) reference periods
    crm_meas_t meas_q, meas_d; // Sequencer state
    logic [17:0] win_q, win_d; // Reference periods counted
    logic [14:0] tick_q, tick_d; // Rate ticks counted
    logic [22:0] ratio_d;
    logic done_d;
    logic [17:0] win_len; // Window length for the chosen band
    assign win_len = 18'h0_0001 << (`CRM_WIN_BASE_EXP + {3'b000, ref_cfg_q.ref_range});

    always_comb begin
        meas_d = meas_q;
        win_d = win_q;
        tick_d = tick_q;
        ratio_d = ratio_q;
        done_d = done_q;
        case (meas_q)
            CRM_IDLE: begin
                win_d = 18'h0_0000;
                tick_d = 15'h0000;
            end
            CRM_RUN: begin
                // Only the reference and the tick feed this; lock path untouched
                if (ref_rise) win_d = win_q + 18'h0_0001;
                if (tick_rise && tick_q != 15'h7FFF) tick_d = tick_q + 15'h0001;
                if (ref_rise && win_q + 18'h0_0001 == win_len) begin
                    ratio_d = {tick_d, 8'h00} >> (5'd8 - `CRM_TICK_SHIFT);
                    done_d = 1'b1;
                    meas_d = CRM_DONE;
                end
            end
            CRM_DONE: begin
                win_d = win_q; // Result held until next restart
            end
            default: meas_d = CRM_IDLE;
        endcase
        // Restart clears flag and begins when enabled
        if (restart_go) begin
            done_d = 1'b0;
            win_d = 18'h0_0000;
            tick_d = 15'h0000;
            meas_d = ref_cfg_q.fine_meas_en ? CRM_RUN : CRM_IDLE;
        end else if (!ref_cfg_q.fine_meas_en && meas_q == CRM_RUN) begin
            meas_d = CRM_IDLE; // Enable dropped mid-way
        end
    end

    // Measurement state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meas_q <= CRM_IDLE;
            win_q <= 18'h0_0000;
            tick_q <= 15'h0000;
            ratio_q <= 23'h00_0000;
            done_q <= 1'b0;
            restart_prev_q <= 1'b0;
            reacq_prev_q <= 1'b0;
        end else begin
            meas_q <= meas_d;
            win_q <= win_d;
            tick_q <= tick_d;
            ratio_q <= ratio_d;
            done_q <= done_d;
            restart_prev_q <= action_q[`CRM_ACT_RESTART_BIT];
            reacq_prev_q <= action_q[`CRM_ACT_REACQ_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output controls, all registered
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            signal_lost_pin <= 1'b0;
            acquire_start <= 1'b0;
            squelch <= 1'b0;
            bypass_en <= 1'b0;
            lvds_off <= 1'b0;
            cml_off <= 1'b0;
            lock_ref_en <= 1'b0;
            ref_lock_cfg <= 6'h00;
            sub_en <= 1'b0;
            sub_ratio <= 5'h00;
            sub_codes <= 20'h0_0000;
            hold_a <= 1'b0;
            hold_b <= 1'b0;
        end else begin
            signal_lost_pin <= sync2_q[3] ^ pol_q[`CRM_POL_LOS_BIT];
            // Software restart always; rate change only outside holdover A
            acquire_start <= reacq_go | (rate_change & ~mode_q[`CRM_MODE_HOLD_A_BIT]);
            squelch <= sub_q.enable & sync2_q[2];
            bypass_en <= path_q.bypass;
            lvds_off <= path_q.lvds_off;
            cml_off <= path_q.cml_off;
            lock_ref_en <= ref_cfg_q.lock_ref_en;
            ref_lock_cfg <= {ref_cfg_q.ref_range, ref_cfg_q.ref_ratio};
            sub_en <= sub_q.enable;
            sub_ratio <= sub_q.ratio;
            sub_codes <= {upper_q, lower_q, sub_q.code_lsb};
            hold_a <= mode_q[`CRM_MODE_HOLD_A_BIT];
            hold_b <= mode_q[`CRM_MODE_HOLD_B_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    restart_clears_done_a: assert property (restart_go |=> !done_q) else $error("done not cleared");
    run_needs_enable_a: assert property (restart_go && ref_cfg_q.fine_meas_en |=> meas_q == CRM_RUN)
        else $error("measurement not started");
    done_matches_state_a: assert property (done_q == (meas_q == CRM_DONE))
        else $error("done flag and state disagree");
    result_holds_a: assert property (meas_q == CRM_DONE && !restart_go |=> $stable(ratio_q) && done_q)
        else $error("result changed before restart");
    los_polarity_a: assert property (##1 signal_lost_pin == ($past(sync2_q[3]) ^ $past(pol_q[2])))
        else $error("signal loss polarity wrong");
    squelch_follow_a: assert property (sub_q.enable && sync2_q[2] |=> squelch)
        else $error("output not squelched");
    hold_a_block_a: assert property (mode_q[2] && !reacq_go |=> !acquire_start)
        else $error("holdover A restarted itself");
    reacq_pulse_a: assert property (reacq_go |=> acquire_start) else $error("re-acquire missed");
    bypass_follow_a: assert property (##1 bypass_en == $past(path_q.bypass))
        else $error("bypass not routed");
    window_len_a: assert property (meas_q == CRM_RUN |-> win_q < win_len)
        else $error("window overran");
    meas_done_c: cover property (meas_q == CRM_RUN ##1 meas_q == CRM_DONE);
    squelch_release_c: cover property (squelch ##1 !squelch);
    rate_change_c: cover property (rate_change && hold_b ##1 acquire_start);

endmodule : crm_top

// ### sim/crm_far_model.sv
// Far-side model: reference clock, data rate tick and loop lock status
`timescale 1ns/1ps
module crm_far_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic acquire_start,
    output logic reference_clock,
    output logic rate_tick,
    output logic lock_lost
);
    int lock_cnt_q; // Cycles left until lock
    // Reference at 120 ns, runs free
    initial begin
        reference_clock = 1'b0;
        forever #60 reference_clock = ~reference_clock;
    end
    // Data rate tick at 320 ns, own phase
    initial begin
        rate_tick = 1'b0;
        #7;
        forever #160 rate_tick = ~rate_tick;
    end
    // Lock is lost for a while after each acquisition request
    always @(posedge clk) begin
        if (!reset_n || acquire_start === 1'b1) lock_cnt_q <= 40;
        else if (lock_cnt_q > 0) lock_cnt_q <= lock_cnt_q - 1;
    end
    assign lock_lost = (lock_cnt_q != 0);
endmodule : crm_far_model

// ### sim/tb_top.sv
// Self-checking bench for the rate meter control block
`timescale 1ns/1ps
module tb_top;
    import crm_pkg::*;
    logic clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reference_clock, rate_tick, lock_lost;
    logic signal_lost, rate_change, signal_lost_pin, acquire_start, squelch, bypass_en, lvds_off, cml_off;
    logic lock_ref_en, sub_en, hold_a, hold_b;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, v, cfg;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [8:0] coarse_rate;
    logic [5:0] ref_lock_cfg;
    logic [4:0] sub_ratio;
    logic [19:0] sub_codes;
    int num_errors, comparisons, n_acq, base;
    ////////////////////////////////////////////////////////////////
    crm_top DUT (
        .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .reference_clock, .rate_tick, .lock_lost, .signal_lost, .rate_change, .coarse_rate,
        .signal_lost_pin, .acquire_start, .squelch, .bypass_en, .lvds_off, .cml_off, .lock_ref_en,
        .ref_lock_cfg, .sub_en, .sub_ratio, .sub_codes, .hold_a, .hold_b
    );
    crm_far_model far_end (.clk, .reset_n, .acquire_start, .reference_clock, .rate_tick, .lock_lost);
    ////////////////////////////////////////////////////////////////
    // Clock, 40 ns
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Count acquisition requests
    always @(posedge clk) if (acquire_start === 1'b1) n_acq <= n_acq + 1;
    // Watchdog, well past the expected run
    initial begin
        #(90_000 * 40);
        num_errors++;
        conclude();
    end
    // Expected ratio: ticks in window times tick prescale
    function automatic logic [31:0] exp_ratio(input int rng, input int ref_ns, input int tick_ns);
        return 32'(((2 ** (14 + rng)) * ref_ns / tick_ns) * 256);
    endfunction : exp_ratio
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Compare with one tick of slack
    task chk_near(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if ((got + 256 >= exp && got <= exp + 256) !== 1'b1) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_near
    // One bus write, response returned
    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic a_t, w_t, b_t;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            a_t = s_axi_awvalid & s_axi_awready;
            w_t = s_axi_wvalid & s_axi_wready;
            b_t = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (a_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end while (b_t !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    // One bus read
    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic a_t, r_t;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            a_t = s_axi_arvalid & s_axi_arready;
            r_t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (a_t) s_axi_arvalid <= 1'b0;
        end while (r_t !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task wr(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d, rsp);
        chk("bresp", 32'h0, 32'(rsp));
    endtask : wr
    task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a, rd, rsp);
        chk("rresp", 32'h0, 32'(rsp));
        chk(what, exp, rd);
    endtask : rd_chk
    // One-then-zero on an action bit
    task pulse(input int b);
        wr(8'h04, 32'h1 << b);
        wr(8'h04, 32'h0);
    endtask : pulse
    task end_test(input string n);
        $display("test %s finished", n);
    endtask : end_test
    task conclude();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {signal_lost, rate_change, reset_n, n_acq} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, coarse_rate} = '0;
        s_axi_wstrb = 4'hF;
        void'($urandom(32'h8249));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        // Every register clears on reset; holes answer with an error
        for (int i = 0; i < 13; i++) rd_chk("reset value", 8'(i * 4), 32'h0);
        axi_rd(8'h34, rd, rsp);
        chk("hole read", 32'h8000_0000, {rsp, rd[29:0]});
        axi_wr(8'h38, 32'h1, rsp);
        chk("hole write", 32'h2, 32'(rsp));
        end_test("reset");
        // Control bits reach their outputs, fine measurement enable left clear
        for (int i = 0; i < 4; i++) begin
            cfg = (i == 0) ? 32'hFD : ($urandom & 32'hFD);
            wr(8'h00, cfg);
            rd_chk("ref config", 8'h00, cfg);
            chk("ref outputs", cfg[7:0], {ref_lock_cfg, 1'b0, lock_ref_en});
            v = (i == 0) ? 32'hE0 : ($urandom & 32'hE0);
            wr(8'h0C, v);
            @(negedge clk);
            chk("path outputs", 32'(v[7:5]), {bypass_en, lvds_off, cml_off});
        end
        end_test("controls");
        // Loss pin polarity, all four combinations
        for (int p = 0; p < 4; p++) begin
            wr(8'h08, 32'(p[1]) << 2);
            signal_lost <= p[0];
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk("loss pin", 32'(p[0] ^ p[1]), 32'(signal_lost_pin));
        end
        end_test("polarity");
        // Coarse word split, read while locked
        coarse_rate <= 9'($urandom);
        @(posedge clk);
        rd_chk("rate code", 8'h20, 32'(coarse_rate[8:1]));
        rd_chk("misc", 8'h1C, 32'(coarse_rate[0]));
        end_test("coarse");
        // Holdover A blocks automatic restarts, B passes them
        base = n_acq;
        wr(8'h30, 32'h4);
        @(posedge clk);
        rate_change <= 1'b1;
        @(posedge clk);
        rate_change <= 1'b0;
        repeat (4) @(posedge clk);
        chk("hold a", 32'h1, 32'(n_acq - base + hold_a));
        pulse(5);
        repeat (4) @(posedge clk);
        chk("reacquire", 32'h1, 32'(n_acq - base));
        rd_chk("cfg kept", 8'h00, cfg);
        wr(8'h30, 32'h2);
        rate_change <= 1'b1;
        @(posedge clk);
        rate_change <= 1'b0;
        repeat (4) @(posedge clk);
        chk("hold b", 32'h3, 32'(n_acq - base + hold_b));
        wr(8'h30, 32'h0);
        end_test("holdover");
        // Subharmonic mode squelches until lock returns
        wr(8'h24, 32'h95);
        wr(8'h28, 32'h1A5);
        wr(8'h2C, 32'h5A);
        repeat (50) @(posedge clk);
        chk("sub outputs", {9'h1A5, 9'h05A, 2'b01, 5'd5, 1'b1, 1'b0}, {sub_codes, sub_ratio, sub_en, squelch});
        pulse(5);
        repeat (8) @(posedge clk);
        chk("squelch on", 32'h1, 32'(squelch));
        repeat (60) @(posedge clk);
        chk("squelch off", 32'h0, 32'(squelch));
        wr(8'h24, 32'h0);
        end_test("subharmonic");
        // Fine measurement, range 0
        base = n_acq;
        wr(8'h00, 32'h2);
        pulse(3);
        rd_chk("done low", 8'h1C, 32'(coarse_rate[0]));
        for (int k = 0; k < 80 && rd[2] !== 1'b1; k++) begin
            repeat (1000) @(posedge clk);
            axi_rd(8'h1C, rd, rsp);
        end
        chk("done high", 32'h1, 32'(rd[2]));
        axi_rd(8'h10, rd, rsp);
        chk("high byte top", 32'h0, rd >> 7);
        v = rd << 16;
        axi_rd(8'h14, rd, rsp);
        v = v | (rd << 8);
        axi_rd(8'h18, rd, rsp);
        chk_near("ratio", exp_ratio(0, 120, 320), v | rd);
        chk("no lock change", 32'h0, 32'(n_acq - base + lock_ref_en + lock_lost));
        repeat (300) @(posedge clk);
        rd_chk("ratio held", 8'h18, v[7:0] | rd);
        pulse(3);
        rd_chk("restarted", 8'h1C, 32'(coarse_rate[0]));
        wr(8'h00, 32'h0);
        end_test("measurement");
        conclude();
    end
endmodule : tb_top
